/* File: sld_pkg.sv */
// Shared constants and carrier types of the segment display driver.
// Assumes one system clock and a software port that uses small word offsets.
package sld_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int SLD_ADDR_W = 2;
  localparam logic [1:0] SLD_OFS_CONTROL = 2'h0;
  localparam logic [1:0] SLD_OFS_RAM_ADDRESS = 2'h1;
  localparam logic [1:0] SLD_OFS_RAM_DATA = 2'h2;
  localparam logic [1:0] SLD_OFS_BOOSTER = 2'h3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] SLD_RST_CONTROL = 8'hc0;
  localparam logic [4:0] SLD_RST_RAM_ADDRESS = 5'h00;
  localparam logic [1:0] SLD_RST_BOOSTER = 2'h0;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SLD_BOOST_LSB = 1;
  localparam int SLD_BOOST_MSB = 2;

  // ****************************************
  // Frame dividers, indexed by the frame rate code
  // ****************************************
  localparam logic [3:0][8:0] SLD_DIV_HALF = {9'h0e8, 9'h130, 9'h118, 9'h100};
  localparam logic [3:0][8:0] SLD_DIV_THIRD = {9'h09c, 9'h0cc, 9'h0bc, 9'h0ac};
  localparam logic [3:0][8:0] SLD_DIV_QUARTER = {9'h074, 9'h098, 9'h08c, 9'h080};

  // ****************************************
  // Drive level codes
  // ****************************************
  localparam logic [1:0] SLD_LVL_GND = 2'h0;
  localparam logic [1:0] SLD_LVL_LOW = 2'h1;
  localparam logic [1:0] SLD_LVL_HIGH = 2'h2;
  localparam logic [1:0] SLD_LVL_TOP = 2'h3;

  typedef struct packed {
    logic biasSelect;
    logic [1:0] dutySelect;
    logic displayEnable;
    logic unusedBit;
    logic driveWaveformType;
    logic [1:0] frameRateSelect;
  } sld_control_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [SLD_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } sld_bus_req_type;

endpackage

/* File: segment_lcd_driver.sv */
// Segment display driver: register port, display RAM, scan timing and drive levels.
// Assumes subOscClk is a slow level synchronous to clk and far below its rate.
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps

// Behaviour
// (RL1) Drives up to 32 segment and 4 common lines, 128 dots.
// (RL2) Keeps running in normal, green and idle processor modes.
// (RL3) All display timing is derived from the sub-oscillator clock.
// (RL4) Bias select bit 7: 0 half bias, 1 one-third bias.
// (RL5) Duty field bits 6:5: 00 half, 01 third, 1x quarter duty.
// (RL6) Enable bit 4 switches the display circuit off or on.
// (RL7) Disabled display holds all common and segment outputs at ground.
// (RL8) Bit 2 selects drive waveform type A or type B.
// (RL9) Frame is sub clock over divider times commons, divider from table.
// (RL10) Address bits 4:0 select segment 0 to 31 one to one.
// (RL11) Data bits 3:0 hold dots; bit n belongs to common n.
// (RL12) Address register bits 7:5 always read zero.
// (RL13) Data buffer bits 7:4 carry no display data.
// (RL14) Booster field bits 2:1 clock pump at Fs, Fs/4, Fs/8, Fs/16.
// (RL15) Data writes store to RAM at address; reads return stored dots.
// (RL16) Scan enabled commons in turn; segments follow the RAM bit.
module segment_lcd_driver
  import sld_pkg::*;
#(
  parameter int SEG_COUNT = 32,
  parameter int COM_COUNT = 4
) (
  input wire logic clk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire sld_bus_req_type busReq, // Register write and read request.
  output logic [7:0] busRdata, // Read data, valid the cycle after a read.
  input wire logic subOscClk, // Sub-oscillator clock level.
  output logic [COM_COUNT-1:0][1:0] comLevel, // Drive level of each common line.
  output logic [SEG_COUNT-1:0][1:0] segLevel, // Drive level of each segment line.
  output logic boosterClk // Charge pump clock.
);

  // ****************************************
  // Registers
  // ****************************************
  sld_control_type ctrl_q;
  logic [4:0] ramAddr_q;
  logic [1:0] boosterSel_q;
  logic [SEG_COUNT-1:0][3:0] ram_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic wrCtrl;
  logic wrAddr;
  logic wrData;
  logic wrBoost;

  assign wrCtrl = busReq.wr && busReq.addr == SLD_OFS_CONTROL;
  assign wrAddr = busReq.wr && busReq.addr == SLD_OFS_RAM_ADDRESS;
  assign wrData = busReq.wr && busReq.addr == SLD_OFS_RAM_DATA;
  assign wrBoost = busReq.wr && busReq.addr == SLD_OFS_BOOSTER;

  // (RL4) Control fields stored.
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= SLD_RST_CONTROL;
    end else if (wrCtrl) begin
      ctrl_q <= busReq.wdata;
      ctrl_q.unusedBit <= 1'b0;
    end
  end

  // (RL10) Address register holds five bits.
  always_ff @(posedge clk) begin
    if (srst) begin
      ramAddr_q <= SLD_RST_RAM_ADDRESS;
    end else if (wrAddr) begin
      ramAddr_q <= busReq.wdata[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      boosterSel_q <= SLD_RST_BOOSTER;
    end else if (wrBoost) begin
      boosterSel_q <= busReq.wdata[SLD_BOOST_MSB:SLD_BOOST_LSB];
    end
  end

  // (RL15) Data writes land in display RAM.
  // The RAM has no reset; software initialises it before enabling the display.
  always_ff @(posedge clk) begin
    if (wrData) begin
      ram_q[ramAddr_q] <= busReq.wdata[3:0];
    end
  end

  // (RL13) Data buffer upper nibble unused.
  // (RL12) Read mux with zero upper bits.
  always_comb begin
    rdata_d = 8'h00;
    case (busReq.addr)
      SLD_OFS_CONTROL: rdata_d = ctrl_q;
      SLD_OFS_RAM_ADDRESS: rdata_d = {3'h0, ramAddr_q};
      SLD_OFS_RAM_DATA: rdata_d = {4'h0, ram_q[ramAddr_q]};
      SLD_OFS_BOOSTER: rdata_d = {5'h00, boosterSel_q, 1'b0};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else if (busReq.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign busRdata = rdata_q;

  // ****************************************
  // Sub-oscillator timing
  // ****************************************
  logic subPrev_q;
  logic subRise;
  logic [3:0] preCnt_q;
  logic boost_q;
  logic [8:0] divider;
  logic [8:0] slotCnt_q;
  logic [1:0] comIdx_q;
  logic [2:0] comCount;
  logic pol_q;

  // (RL3) Timing advances only on sub-oscillator rising edges.
  // The processor mode is not an input, so the scan runs in every mode that keeps Fs alive.
  always_ff @(posedge clk) begin
    if (srst) begin
      subPrev_q <= 1'b0;
    end else begin
      subPrev_q <= subOscClk;
    end
  end
  // (RL2) No mode gating on the sub clock edge.
  assign subRise = subOscClk && !subPrev_q;

  // (RL14) Booster prescaler.
  always_ff @(posedge clk) begin
    if (srst) begin
      preCnt_q <= 4'h0;
    end else if (subRise) begin
      preCnt_q <= preCnt_q + 4'h1;
    end
  end

  // (RL14) Booster clock divide select.
  always_ff @(posedge clk) begin
    if (srst) begin
      boost_q <= 1'b0;
    end else begin
      case (boosterSel_q)
        2'h0: boost_q <= subOscClk;
        2'h1: boost_q <= preCnt_q[1];
        2'h2: boost_q <= preCnt_q[2];
        2'h3: boost_q <= preCnt_q[3];
        default: boost_q <= 1'b0;
      endcase
    end
  end
  assign boosterClk = boost_q;

  // (RL5) Duty picks common count and divider row.
  // (RL9) Divider from frame rate code.
  always_comb begin
    case (ctrl_q.dutySelect)
      2'h0: begin
        comCount = 3'h2;
        divider = SLD_DIV_HALF[ctrl_q.frameRateSelect];
      end
      2'h1: begin
        comCount = 3'h3;
        divider = SLD_DIV_THIRD[ctrl_q.frameRateSelect];
      end
      default: begin
        comCount = 3'h4;
        divider = SLD_DIV_QUARTER[ctrl_q.frameRateSelect];
      end
    endcase
  end

  // (RL9) One common slot lasts divider sub clocks.
  // A divider change that leaves the count at or past the new divider restarts the slot rather than overrun it.
  always_ff @(posedge clk) begin
    if (srst || !ctrl_q.displayEnable) begin
      slotCnt_q <= 9'h000;
    end else if (slotCnt_q >= divider) begin
      slotCnt_q <= 9'h000;
    end else if (subRise) begin
      slotCnt_q <= (slotCnt_q == divider - 9'h001) ? 9'h000 : slotCnt_q + 9'h001;
    end
  end

  // (RL16) Step through the enabled commons.
  always_ff @(posedge clk) begin
    if (srst || !ctrl_q.displayEnable) begin
      comIdx_q <= 2'h0;
    end else if ({1'b0, comIdx_q} >= comCount) begin
      comIdx_q <= 2'h0;
    end else if (subRise && slotCnt_q == divider - 9'h001) begin
      comIdx_q <= ({1'b0, comIdx_q} == comCount - 3'h1) ? 2'h0 : comIdx_q + 2'h1;
    end
  end

  // (RL8) Type A flips polarity each half slot, type B once per frame.
  always_ff @(posedge clk) begin
    if (srst || !ctrl_q.displayEnable) begin
      pol_q <= 1'b0;
    end else if (subRise) begin
      if (!ctrl_q.driveWaveformType) begin
        if (slotCnt_q == (divider >> 1) - 9'h001 || slotCnt_q == divider - 9'h001) begin
          pol_q <= !pol_q;
        end
      end else if (slotCnt_q == divider - 9'h001 && {1'b0, comIdx_q} == comCount - 3'h1) begin
        pol_q <= !pol_q;
      end
    end
  end

  // ****************************************
  // Drive levels
  // ****************************************
  logic [1:0] maxLvl;
  logic [1:0] selLvl;
  logic [1:0] unselLvl;
  logic [1:0] onLvl;
  logic [1:0] offLvl;

  // (RL4) Bias sets the level ladder.
  always_comb begin
    maxLvl = ctrl_q.biasSelect ? SLD_LVL_TOP : SLD_LVL_HIGH;
    selLvl = pol_q ? SLD_LVL_GND : maxLvl;
    onLvl = pol_q ? maxLvl : SLD_LVL_GND;
    if (ctrl_q.biasSelect) begin
      unselLvl = pol_q ? SLD_LVL_HIGH : SLD_LVL_LOW;
      offLvl = pol_q ? SLD_LVL_LOW : SLD_LVL_HIGH;
    end else begin
      unselLvl = SLD_LVL_LOW;
      offLvl = selLvl;
    end
  end

  // (RL1) One driver per common line.
  for (genvar c = 0; c < COM_COUNT; c++) begin : gen_com
    always_ff @(posedge clk) begin
      // (RL7) Ground when disabled.
      if (srst || !ctrl_q.displayEnable) begin
        comLevel[c] <= SLD_LVL_GND;
      end else if (c == int'(comIdx_q)) begin
        comLevel[c] <= selLvl;
      end else begin
        comLevel[c] <= unselLvl;
      end
    end
  end

  // (RL11) Segment takes the RAM bit of the active common.
  for (genvar s = 0; s < SEG_COUNT; s++) begin : gen_seg
    always_ff @(posedge clk) begin
      // (RL6) Enable gates every segment.
      if (srst || !ctrl_q.displayEnable) begin
        segLevel[s] <= SLD_LVL_GND;
      end else begin
        segLevel[s] <= ram_q[s][comIdx_q] ? onLvl : offLvl;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic anyTop;
  always_comb begin
    anyTop = 1'b0;
    for (int i = 0; i < COM_COUNT; i++) begin
      anyTop = anyTop | (comLevel[i] == SLD_LVL_TOP);
    end
    for (int i = 0; i < SEG_COUNT; i++) begin
      anyTop = anyTop | (segLevel[i] == SLD_LVL_TOP);
    end
  end

  a_disabled_ground: assert property (@(posedge clk) disable iff (srst) // RL7
    !ctrl_q.displayEnable |=> (comLevel == '0 && segLevel == '0))
    else $error("outputs not grounded while display disabled");

  a_half_bias_levels: assert property (@(posedge clk) disable iff (srst) // RL4
    (!ctrl_q.biasSelect && $past(!ctrl_q.biasSelect)) |-> !anyTop)
    else $error("top level driven under half bias");

  a_addr_upper_zero: assert property (@(posedge clk) disable iff (srst) // RL12
    (busReq.rd && busReq.addr == SLD_OFS_RAM_ADDRESS) |=> busRdata[7:5] == 3'h0)
    else $error("address register upper bits not zero");

  a_data_upper_zero: assert property (@(posedge clk) disable iff (srst) // RL13
    (busReq.rd && busReq.addr == SLD_OFS_RAM_DATA) |=> busRdata[7:4] == 4'h0)
    else $error("data buffer upper bits not zero");

  a_ram_write_store: assert property (@(posedge clk) disable iff (srst) // RL15
    wrData |=> ram_q[$past(ramAddr_q)] == $past(busReq.wdata[3:0]))
    else $error("data write not stored at current address");

  a_ram_read_back: assert property (@(posedge clk) disable iff (srst) // RL10
    (busReq.rd && busReq.addr == SLD_OFS_RAM_DATA) |=>
      busRdata[3:0] == $past(ram_q[ramAddr_q]))
    else $error("data read does not return addressed dots");

  // A control write may shorten the divider; the slot then restarts one cycle later.
  a_slot_bound: assert property (@(posedge clk) disable iff (srst) // RL9
    (ctrl_q.displayEnable && !wrCtrl) |=> slotCnt_q < divider)
    else $error("slot counter passed its divider");

  a_com_bound: assert property (@(posedge clk) disable iff (srst) // RL5
    (ctrl_q.displayEnable && !wrCtrl) |=> {1'b0, comIdx_q} < comCount)
    else $error("common index beyond duty");

  a_prescale_step: assert property (@(posedge clk) disable iff (srst) // RL14
    subRise |=> preCnt_q == $past(preCnt_q) + 4'h1)
    else $error("booster prescaler did not step");

  a_boost_follow: assert property (@(posedge clk) disable iff (srst) // RL14
    boosterSel_q == 2'h0 |=> boosterClk == $past(subOscClk))
    else $error("booster clock does not follow the sub clock");

  a_com_select: assert property (@(posedge clk) disable iff (srst) // RL16
    ctrl_q.displayEnable |=> comLevel[$past(comIdx_q)] == $past(selLvl))
    else $error("active common not at select level");

  a_seg_follow: assert property (@(posedge clk) disable iff (srst) // RL11
    ctrl_q.displayEnable |=>
      segLevel[0] == ($past(ram_q[0][comIdx_q]) ? $past(onLvl) : $past(offLvl)))
    else $error("segment level does not follow its dot");

  a_slot_advance: assert property (@(posedge clk) disable iff (srst) // RL16
    (ctrl_q.displayEnable && subRise && slotCnt_q == divider - 9'h001 &&
      {1'b0, comIdx_q} < comCount - 3'h1 && $stable(ctrl_q)) |=>
      comIdx_q == $past(comIdx_q) + 2'h1)
    else $error("common did not advance at slot end");

endmodule

/* File: seg_panel_model.sv */
// Behavioural model of the segment glass that the driver faces.
// Assumes the level codes of the driver: 0 ground up to 3 top level.
`timescale 1ns/1ps

module seg_panel_model
  import sld_pkg::*;
(
  input wire logic [3:0][1:0] comLevel, // Level on each common electrode.
  input wire logic [31:0][1:0] segLevel, // Level on each segment electrode.
  output logic [3:0][31:0] litMap // Dots that see a full select voltage.
);
  // A dot turns dark only when its two electrodes stand two or more steps
  // apart; the one-step bias swing of unselected dots must stay clear.
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 32; s++) begin
        litMap[c][s] = (int'(comLevel[c]) - int'(segLevel[s]) >= 2) ||
                       (int'(segLevel[s]) - int'(comLevel[c]) >= 2);
      end
    end
  end
endmodule

/* File: tb.sv */
// Self-checking bench of the segment display driver with a glass model.
// Assumes the register offsets and struct types of sld_pkg.
`timescale 1ns/1ps

module tb;
  import sld_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  sld_bus_req_type busReq = '0;
  logic [7:0] busRdata;
  logic subOscClk = 1'b0;
  logic [3:0][1:0] comLevel;
  logic [31:0][1:0] segLevel;
  logic boosterClk;
  logic [3:0][31:0] litMap;
  logic [2:0] subCnt = 3'h0;
  logic [3:0] ram [32];
  int mismatches = 0;
  int checksDone = 0;

  always #20 clk = ~clk;
  // The sub clock runs at one eighth of clk, slow enough for the scan latency.
  always @(posedge clk) begin
    subCnt <= subCnt + 3'h1;
    subOscClk <= subCnt[2];
  end

  segment_lcd_driver i_segment_lcd_driver (.clk(clk), .srst(srst), .busReq(busReq),
    .busRdata(busRdata), .subOscClk(subOscClk), .comLevel(comLevel),
    .segLevel(segLevel), .boosterClk(boosterClk));
  seg_panel_model i_seg_panel_model (.comLevel(comLevel), .segLevel(segLevel),
    .litMap(litMap));

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge clk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    busReq <= '0;
  endtask

  task automatic rd(logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    busReq <= '0;
    #1 v = busRdata;
  endtask

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic endOfTest();
    if (mismatches == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic int divOf(int d, int f);
    int t [3][4] = '{'{256, 280, 304, 232}, '{172, 188, 204, 156}, '{128, 140, 152, 116}};
    return t[(d > 1) ? 2 : d][f];
  endfunction

  function automatic int selOf(int n, int mx);
    for (int c = 0; c < n; c++) begin
      if (comLevel[c] == mx || comLevel[c] == 0) return c;
    end
    return -1;
  endfunction

  function automatic logic [31:0] rowOf(int c);
    logic [31:0] r;
    for (int s = 0; s < 32; s++) r[s] = ram[s][c];
    return r;
  endfunction

  // ****************************************
  // Scan timing of one duty and frame setting
  // ****************************************
  task automatic runCombo(int d, int f);
    logic [7:0] ctl;
    int n, mx, prev, subs, lvl0, guard;
    bit flip, subPrev;
    ctl = {f[0], d[1:0], 1'b0, 1'b0, f[1], f[1:0]};
    n = (d == 0) ? 2 : (d == 1) ? 3 : 4;
    mx = f[0] ? 3 : 2;
    wr(SLD_OFS_CONTROL, ctl);
    wr(SLD_OFS_CONTROL, ctl | 8'h10);
    prev = 0;
    guard = 0;
    while (selOf(n, mx) == prev && guard < 3000) begin
      @(posedge clk);
      guard++;
    end
    prev = selOf(n, mx);
    lvl0 = comLevel[prev];
    subs = 0;
    flip = 0;
    subPrev = subOscClk;
    while (selOf(n, mx) == prev && subs < 400) begin
      @(posedge clk);
      if (subOscClk && !subPrev) subs++;
      subPrev = subOscClk;
      if (selOf(n, mx) == prev && comLevel[prev] != lvl0) flip = 1;
      if (subs == 5 && subOscClk && prev >= 0) check("lit row", litMap[prev], rowOf(prev));
    end
    check("slot length", subs, divOf(d, f));
    check("next common", selOf(n, mx), (prev + 1) % n);
    check("in-slot flip", flip, !f[1]);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] v, r;
    int cnt;
    bit bPrev;
    void'($urandom(32'hf25a));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(SLD_OFS_CONTROL, v);
    check("control reset", v, 8'hc0);
    rd(SLD_OFS_RAM_ADDRESS, v);
    check("address reset", v, 8'h00);
    wr(SLD_OFS_RAM_ADDRESS, 8'hff);
    rd(SLD_OFS_RAM_ADDRESS, v);
    check("address top bits", v, 8'h1f);
    for (int a = 0; a < 32; a++) begin
      r = $urandom();
      wr(SLD_OFS_RAM_ADDRESS, {r[7:5], a[4:0]});
      r = $urandom();
      wr(SLD_OFS_RAM_DATA, r);
      ram[a] = r[3:0];
    end
    for (int a = 31; a >= 0; a--) begin
      wr(SLD_OFS_RAM_ADDRESS, a[7:0]);
      rd(SLD_OFS_RAM_DATA, v);
      check("ram readback", v, {4'h0, ram[a]});
    end
    r = $urandom();
    wr(SLD_OFS_CONTROL, (r & 8'hef) | 8'h08);
    rd(SLD_OFS_CONTROL, v);
    check("control readback", v, r & 8'he7);
    repeat (40) @(posedge clk);
    check("common off", comLevel, 8'h00);
    check("segment off", segLevel, 64'h0);
    wr(SLD_OFS_CONTROL, 8'h10);
    for (int b = 0; b < 4; b++) begin
      r = $urandom();
      wr(SLD_OFS_BOOSTER, {r[7:3], b[1:0], r[0]});
      rd(SLD_OFS_BOOSTER, v);
      check("booster readback", v, {5'h00, b[1:0], 1'b0});
      repeat (64) @(posedge clk);
      cnt = 0;
      bPrev = boosterClk;
      repeat (512) begin
        @(posedge clk);
        if (boosterClk && !bPrev) cnt++;
        bPrev = boosterClk;
      end
      check("booster rate", cnt, (b == 0) ? 64 : 64 >> (b + 1));
    end
    for (int d = 0; d < 4; d++) begin
      for (int f = 0; f < 4; f++) begin
        if (d < 3 || f == 0) runCombo(d, f);
      end
    end
    endOfTest();
  end

  // The scan waits have their own guards; as a backstop, cut the run off well past the expected run.
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    endOfTest();
  end
endmodule
